// ### common/ppdd_pkg.sv
// Constants shared by the parallel port direction and data block.
// Contract
// R1: port 7 read returns live pin levels
// R2: port 8 data bits 4:0, upper read one
// R3: port 9 direction six write-only bits
// R4: direction zero input, one output
// R5: port A direction top bit mode dependent
// R6: port 9 data six bits, upper read one
// R7: port A data eight bits, reset zero
// R8: port B direction write-only, bit 6 pinless
// R9: output pins driven, input pins released
package ppdd_pkg;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] PPDD_ADDR_PORT7_IN = 8'hce;
   localparam logic [7:0] PPDD_ADDR_PORT8_DATA = 8'hcf;
   localparam logic [7:0] PPDD_ADDR_PORT9_DIR = 8'hd0;
   localparam logic [7:0] PPDD_ADDR_PORTA_DIR = 8'hd1;
   localparam logic [7:0] PPDD_ADDR_PORT9_DATA = 8'hd2;
   localparam logic [7:0] PPDD_ADDR_PORTA_DATA = 8'hd3;
   localparam logic [7:0] PPDD_ADDR_PORTB_DIR = 8'hd4;

   // -----------------------------------------------------------------
   // Reset values and read fill
   // -----------------------------------------------------------------
   localparam logic [4:0] PPDD_PORT8_DATA_RST = 5'h00;
   localparam logic [5:0] PPDD_PORT9_DIR_RST = 6'h00;
   localparam logic [5:0] PPDD_PORT9_DATA_RST = 6'h00;
   localparam logic [7:0] PPDD_PORTA_DIR_RST = 8'h00;
   localparam logic [7:0] PPDD_PORTA_DATA_RST = 8'h00;
   localparam logic [7:0] PPDD_PORTB_DIR_RST = 8'h00;
   localparam logic [2:0] PPDD_PORT8_FILL = 3'h7;
   localparam logic [1:0] PPDD_PORT9_FILL = 2'h3;
   localparam logic [7:0] PPDD_WRITE_ONLY_READ = 8'hff;
   localparam logic [7:0] PPDD_UNMAPPED_READ = 8'h00;
   localparam logic [7:0] PPDD_IDLE_READ = 8'h00;
   localparam logic [7:0] PPDD_OE_N_RST = 8'hff;

   // -----------------------------------------------------------------
   // Field positions and modes
   // -----------------------------------------------------------------
   localparam int PPDD_PORTA_TOP_BIT = 7;
   localparam int PPDD_PORTB_NOPIN_BIT = 6;
   localparam logic [2:0] PPDD_MODE_TOP_LOCK_A = 3'h3;
   localparam logic [2:0] PPDD_MODE_TOP_LOCK_B = 3'h6;
   localparam logic [2:0] PPDD_MODE_RST = 3'h0;
   localparam logic [2:0] PPDD_MODE_SETTLE_CYCLES = 3'h4;
endpackage

// ### hdl/ppdd_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
module ppdd_pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] stable_out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] hold_r;
   logic [WIDTH-1:0] stable_r;
   wire logic agree;
   wire logic [WIDTH-1:0] stable_nxt;

   // Only the second and third stages are compared; the first may be metastable.
   assign agree = (sync_r == hold_r);
   assign stable_nxt = agree ? hold_r : stable_r;
   assign stable_out = stable_r;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         meta_r <= '0;
         sync_r <= '0;
         hold_r <= '0;
         stable_r <= '0;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         hold_r <= sync_r;
         stable_r <= stable_nxt;
      end
   end
endmodule

// ### hdl/ppdd_top.sv
// Parallel port direction and data registers with pin drive.
module ppdd_top
   import ppdd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rd_data,
   input wire logic [7:0] port7_pins,
   input wire logic [2:0] mode_pins,
   output logic [4:0] port8_out,
   output logic [5:0] port9_out,
   output logic [5:0] port9_oe_n,
   output logic [7:0] porta_out,
   output logic [7:0] porta_oe_n,
   output logic [7:0] portb_oe_n
);
   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   logic [7:0] rd_data_r;
   logic [4:0] port8_data_r;
   logic [5:0] port9_dir_r;
   logic [5:0] port9_data_r;
   logic [7:0] porta_dir_r;
   logic [7:0] porta_data_r;
   logic [7:0] portb_dir_r;
   logic [5:0] port9_oe_n_r;
   logic [7:0] porta_oe_n_r;
   logic [7:0] portb_oe_n_r;
   logic [2:0] mode_r;
   logic mode_valid_r;
   logic [2:0] settle_cnt_r;

   wire logic [7:0] port7_level;
   wire logic [2:0] mode_level;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   ppdd_pin_sync #(.WIDTH(8)) u_port7_sync (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin_in(port7_pins),
      .stable_out(port7_level)
   );

   ppdd_pin_sync #(.WIDTH(3)) u_mode_sync (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin_in(mode_pins),
      .stable_out(mode_level)
   );

   // -----------------------------------------------------------------
   // Mode capture
   // -----------------------------------------------------------------
   // The strap is caught a few cycles after release so the synchroniser has settled.
   wire logic settle_done;
   wire logic mode_take;
   wire logic [2:0] settle_cnt_nxt;
   wire logic top_lock;
   wire logic top_lock_nxt;
   wire logic lock_after;

   assign settle_done = (settle_cnt_r == PPDD_MODE_SETTLE_CYCLES);
   assign mode_take = settle_done && !mode_valid_r;
   assign settle_cnt_nxt = settle_done ? settle_cnt_r : settle_cnt_r + 3'h1;
   assign top_lock = mode_valid_r &&
      ((mode_r == PPDD_MODE_TOP_LOCK_A) || (mode_r == PPDD_MODE_TOP_LOCK_B)); // R5
   assign top_lock_nxt = (mode_level == PPDD_MODE_TOP_LOCK_A) || (mode_level == PPDD_MODE_TOP_LOCK_B);
   // The lock already applies in the cycle that takes the strap, so the top bit sets at capture.
   assign lock_after = mode_take ? top_lock_nxt : top_lock; // R5

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         settle_cnt_r <= 3'h0;
         mode_valid_r <= 1'b0;
         mode_r <= PPDD_MODE_RST;
      end else begin
         settle_cnt_r <= settle_cnt_nxt;
         if (mode_take) begin
            mode_valid_r <= 1'b1;
            mode_r <= mode_level;
         end
      end
   end

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   wire logic hit_port8_data;
   wire logic hit_port9_dir;
   wire logic hit_port9_data;
   wire logic hit_porta_dir;
   wire logic hit_porta_data;
   wire logic hit_portb_dir;

   assign hit_port8_data = wr_stb && (addr == PPDD_ADDR_PORT8_DATA);
   assign hit_port9_dir = wr_stb && (addr == PPDD_ADDR_PORT9_DIR);
   assign hit_port9_data = wr_stb && (addr == PPDD_ADDR_PORT9_DATA);
   assign hit_porta_dir = wr_stb && (addr == PPDD_ADDR_PORTA_DIR);
   assign hit_porta_data = wr_stb && (addr == PPDD_ADDR_PORTA_DATA);
   assign hit_portb_dir = wr_stb && (addr == PPDD_ADDR_PORTB_DIR);

   // -----------------------------------------------------------------
   // Next register values
   // -----------------------------------------------------------------
   wire logic [4:0] port8_data_nxt;
   wire logic [5:0] port9_dir_nxt;
   wire logic [5:0] port9_data_nxt;
   wire logic [7:0] porta_dir_wr;
   wire logic [7:0] porta_dir_nxt;
   wire logic [7:0] porta_data_nxt;
   wire logic [7:0] portb_dir_nxt;

   assign port8_data_nxt = hit_port8_data ? wr_data[4:0] : port8_data_r; // R2
   assign port9_dir_nxt = hit_port9_dir ? wr_data[5:0] : port9_dir_r; // R3
   assign port9_data_nxt = hit_port9_data ? wr_data[5:0] : port9_data_r; // R6
   assign porta_data_nxt = hit_porta_data ? wr_data : porta_data_r; // R7
   assign portb_dir_nxt = hit_portb_dir ? wr_data : portb_dir_r; // R8

   // In the locked modes the top bit is forced to one and ignores writes.
   assign porta_dir_wr = hit_porta_dir ? wr_data : porta_dir_r;
   assign porta_dir_nxt = {lock_after | porta_dir_wr[PPDD_PORTA_TOP_BIT],
      porta_dir_wr[PPDD_PORTA_TOP_BIT-1:0]}; // R5

   // -----------------------------------------------------------------
   // Pin drive enables, low while driving
   // -----------------------------------------------------------------
   wire logic [5:0] port9_oe_n_nxt;
   wire logic [7:0] porta_oe_n_nxt;
   wire logic [7:0] portb_oe_n_nxt;

   assign port9_oe_n_nxt = ~port9_dir_nxt; // R4 R9
   // The locked top pin belongs to other logic, so it is never driven here.
   assign porta_oe_n_nxt = {~porta_dir_nxt[PPDD_PORTA_TOP_BIT] | lock_after,
      ~porta_dir_nxt[PPDD_PORTA_TOP_BIT-1:0]}; // R4 R9
   assign portb_oe_n_nxt = ~portb_dir_nxt | (8'h01 << PPDD_PORTB_NOPIN_BIT); // R8 R9

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         port8_data_r <= PPDD_PORT8_DATA_RST;
         port9_dir_r <= PPDD_PORT9_DIR_RST;
         port9_data_r <= PPDD_PORT9_DATA_RST;
         porta_dir_r <= PPDD_PORTA_DIR_RST;
         porta_data_r <= PPDD_PORTA_DATA_RST;
         portb_dir_r <= PPDD_PORTB_DIR_RST;
         port9_oe_n_r <= PPDD_OE_N_RST[5:0];
         porta_oe_n_r <= PPDD_OE_N_RST;
         portb_oe_n_r <= PPDD_OE_N_RST;
      end else begin
         port8_data_r <= port8_data_nxt;
         port9_dir_r <= port9_dir_nxt;
         port9_data_r <= port9_data_nxt;
         porta_dir_r <= porta_dir_nxt;
         porta_data_r <= porta_data_nxt;
         portb_dir_r <= portb_dir_nxt;
         port9_oe_n_r <= port9_oe_n_nxt;
         porta_oe_n_r <= porta_oe_n_nxt;
         portb_oe_n_r <= portb_oe_n_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   // Direction registers are write-only, so their reads carry no state.
   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = PPDD_UNMAPPED_READ;
      unique case (addr)
         PPDD_ADDR_PORT7_IN: rd_mux = port7_level; // R1
         PPDD_ADDR_PORT8_DATA: rd_mux = {PPDD_PORT8_FILL, port8_data_r}; // R2
         PPDD_ADDR_PORT9_DIR: rd_mux = PPDD_WRITE_ONLY_READ; // R3
         PPDD_ADDR_PORT9_DATA: rd_mux = {PPDD_PORT9_FILL, port9_data_r}; // R6
         PPDD_ADDR_PORTA_DIR: rd_mux = PPDD_WRITE_ONLY_READ; // R5
         PPDD_ADDR_PORTA_DATA: rd_mux = porta_data_r; // R7
         PPDD_ADDR_PORTB_DIR: rd_mux = PPDD_WRITE_ONLY_READ; // R8
         default: rd_mux = PPDD_UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_data_r <= PPDD_IDLE_READ;
      end else begin
         rd_data_r <= rd_stb ? rd_mux : PPDD_IDLE_READ;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign rd_data = rd_data_r;
   assign port8_out = port8_data_r;
   assign port9_out = port9_data_r; // R9
   assign port9_oe_n = port9_oe_n_r;
   assign porta_out = porta_data_r; // R9
   assign porta_oe_n = porta_oe_n_r;
   assign portb_oe_n = portb_oe_n_r;
endmodule

// ### testbench/ppdd_top_asserts.sv
// Port behaviour assertions for the parallel port block.
module ppdd_top_asserts (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic [7:0] port7_pins,
   input wire logic [2:0] mode_pins,
   input wire logic [4:0] port8_out,
   input wire logic [5:0] port9_out,
   input wire logic [5:0] port9_oe_n,
   input wire logic [7:0] porta_out,
   input wire logic [7:0] porta_oe_n,
   input wire logic [7:0] portb_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wd_r;
   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   // Write data is kept one cycle so checks can see what was written.
   always_ff @(posedge clk_sys) wd_r <= wr_data;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_rd_idle_zero: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
      else $error("read data not idle");
   a_p8_read_fill: assert property (rd_stb && addr == 8'hcf |=> rd_data == {3'h7, port8_out})
      else $error("port 8 read wrong");
   a_p9dir_read_ones: assert property (rd_stb && addr == 8'hd0 |=> rd_data == 8'hff)
      else $error("port 9 direction read wrong");
   a_p9_read_fill: assert property (rd_stb && addr == 8'hd2 |=> rd_data == {2'h3, port9_out})
      else $error("port 9 data read wrong");
   a_pa_read_back: assert property (rd_stb && addr == 8'hd3 |=> rd_data == porta_out)
      else $error("port A data read wrong");
   a_pa_data_hold: assert property (!(wr_stb && addr == 8'hd3) |=> $stable(porta_out))
      else $error("port A data changed without write");
   a_p9_dir_drive: assert property (wr_stb && addr == 8'hd0 |=> port9_oe_n == ~wd_r[5:0])
      else $error("port 9 drive enable wrong");
   a_pb_dir_drive: assert property (wr_stb && addr == 8'hd4 |=> portb_oe_n == (~wd_r | 8'h40))
      else $error("port B drive enable wrong");
   a_pa_top_lock: assert property ((mode_pins == 3'h3 || mode_pins == 3'h6) |-> porta_oe_n[7])
      else $error("port A top pin driven");
   a_p7_live_read: assert property ($stable(port7_pins)[*6] ##0 (rd_stb && addr == 8'hce)
      |=> rd_data == $past(port7_pins))
      else $error("port 7 read not live");
endmodule
bind ppdd_top ppdd_top_asserts i_ppdd_top_asserts (.clk_sys(clk_sys), .resetn(resetn), .addr(addr),
   .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .port7_pins(port7_pins),
   .mode_pins(mode_pins), .port8_out(port8_out), .port9_out(port9_out), .port9_oe_n(port9_oe_n),
   .porta_out(porta_out), .porta_oe_n(porta_oe_n), .portb_oe_n(portb_oe_n));

// ### testbench/ppdd_pin_model.sv
// Model of the external drivers on the input-only port.
module ppdd_pin_model (
   input wire logic [7:0] level,
   output logic [7:0] port7_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // The outside world always drives these pins; they have no float state.
   assign port7_pins = level;
endmodule

// ### testbench/tb_ppdd_top.sv
// Directed testbench for the parallel port block.
module tb_ppdd_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, resetn, wr_stb, rd_stb;
   logic [7:0] addr, wr_data, rd_data, level, port7_pins, porta_out, porta_oe_n, portb_oe_n;
   logic [2:0] mode_pins;
   logic [4:0] port8_out;
   logic [5:0] port9_out, port9_oe_n;
   int bad_count, cmp_count;
   logic [7:0] ra [7] = '{8'hcf, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5};
   logic [7:0] re [7] = '{8'he0, 8'hff, 8'hff, 8'hc0, 8'h00, 8'hff, 8'h00};
   ppdd_pin_model i_ppdd_pin_model (.level(level), .port7_pins(port7_pins));
   ppdd_top i_ppdd_top (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .port7_pins(port7_pins),
      .mode_pins(mode_pins), .port8_out(port8_out), .port9_out(port9_out), .port9_oe_n(port9_oe_n),
      .porta_out(porta_out), .porta_oe_n(porta_oe_n), .portb_oe_n(portb_oe_n));
   // -----------------------------------------------------------------
   // Bus tasks
   // -----------------------------------------------------------------
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1 chk($sformatf("read %h", a), e, rd_data);
   endtask
   task automatic do_reset(logic [2:0] m);
      resetn <= 1'b0;
      mode_pins <= m;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (8) @(posedge clk_sys);
      #1;
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      #50000;
      bad_count++;
      end_of_test();
   end
   initial begin
      {resetn, wr_stb, rd_stb, addr, wr_data, level, mode_pins} = '0;
      do_reset(3'h3);
      chk("porta_oe_n", 8'hff, porta_oe_n);
      chk("portb_oe_n", 8'hff, portb_oe_n);
      chk("port9_oe_n", 8'h3f, {2'h0, port9_oe_n});
      for (int i = 0; i < 7; i++) rd(ra[i], re[i]);
      $display("test reset values done");
      level <= 8'ha5;
      repeat (8) @(posedge clk_sys);
      rd(8'hce, 8'ha5);
      level <= 8'h5a;
      wr(8'hce, 8'h00);
      repeat (8) @(posedge clk_sys);
      rd(8'hce, 8'h5a);
      $display("test live pins done");
      wr(8'hcf, 8'hff);
      chk("port8_out", 8'h1f, {3'h0, port8_out});
      rd(8'hcf, 8'hff);
      wr(8'hcf, 8'h0a);
      rd(8'hcf, 8'hea);
      wr(8'hd2, 8'hff);
      rd(8'hd2, 8'hff);
      chk("port9_out", 8'h3f, {2'h0, port9_out});
      wr(8'hd0, 8'h05);
      chk("port9_oe_n", 8'h3a, {2'h0, port9_oe_n});
      rd(8'hd0, 8'hff);
      wr(8'hd3, 8'ha5);
      rd(8'hd3, 8'ha5);
      chk("porta_out", 8'ha5, porta_out);
      wr(8'hd1, 8'hff);
      chk("porta_oe_n", 8'h80, porta_oe_n);
      wr(8'hd4, 8'hff);
      chk("portb_oe_n", 8'h40, portb_oe_n);
      wr(8'hd4, 8'h80);
      chk("portb_oe_n", 8'h7f, portb_oe_n);
      $display("test writes in locked mode done");
      do_reset(3'h1);
      chk("porta_oe_n", 8'hff, porta_oe_n);
      chk("porta_out", 8'h00, porta_out);
      chk("portb_oe_n", 8'hff, portb_oe_n);
      chk("port9_oe_n", 8'h3f, {2'h0, port9_oe_n});
      chk("port9_out", 8'h00, {2'h0, port9_out});
      rd(8'hcf, 8'he0);
      wr(8'hd1, 8'hff);
      chk("porta_oe_n", 8'h00, porta_oe_n);
      wr(8'hd1, 8'h7f);
      chk("porta_oe_n", 8'h80, porta_oe_n);
      $display("test open mode done");
      do_reset(3'h6);
      chk("porta_oe_n", 8'hff, porta_oe_n);
      wr(8'hd1, 8'hff);
      chk("porta_oe_n", 8'h80, porta_oe_n);
      wr(8'hd3, 8'h3c);
      chk("porta_out", 8'h3c, porta_out);
      $display("test mode six done");
      do_reset(3'h7);
      wr(8'hd1, 8'hff);
      chk("porta_oe_n", 8'h00, porta_oe_n);
      $display("test mode seven done");
      end_of_test();
   end
endmodule
